// >>> rtl/frt_pkg.sv
/*
 * constants for the fixed rate interval timer: register map, field
 * positions, reset values and timing counts.
 * assumes a single 250 mhz pclk that also stands for the oscillator.
 */
`default_nettype none

package frt_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SERIAL_CONFIG_OFS = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] COUNT_OFS = 8'h10;
  localparam logic [7:0] CORE_STATE_OFS = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SLAVE_ENABLE_POS = 0;
  localparam int BUS_OWN_REQ_POS = 1;
  localparam int BUS_OWNER_POS = 2;
  localparam int TIMER_RUN_POS = 4;
  localparam int TIMER_FLAG_CLEAR_POS = 5;
  localparam int TIMER_IRQ_EN_POS = 4;
  localparam int GLOBAL_IRQ_EN_POS = 7;
  localparam int ST_TIMER_POS = 0;
  localparam int ST_BUS_TMO_POS = 1;
  localparam int IN_PROGRESS_POS = 0;

  // ----------------------------------------------------------------
  // reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] MASK_RESET = 2'h3;
  localparam logic [7:0] TIMER_VECTOR = 8'h1b;
  localparam int CNT_W = 10;
  localparam int MACHINE_DIV = 12;
endpackage

`default_nettype wire

// >>> rtl/frt_mc_tick.sv
/*
 * machine cycle prescaler: one pclk-wide tick every div pclk cycles.
 * assumes pclk stands for the oscillator of the processor.
 */
`default_nettype none

module frt_mc_tick #(
  parameter int DIV = frt_pkg::MACHINE_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic mc_tick
);
  localparam int W = $clog2(DIV);

  initial begin
    if (DIV < 2) begin
      $error("frt_mc_tick: DIV must be at least 2");
    end
  end

  logic [W-1:0] div_reg;
  logic [W-1:0] div_next;

  always_comb begin
    if (div_reg == W'(DIV - 1)) begin
      div_next = '0;
    end else begin
      div_next = div_reg + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign mc_tick = (div_reg == W'(DIV - 1));

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tick_period: assert property (mc_tick |-> ##12 mc_tick)
    else $error("machine tick period is not twelve clocks");
  a_tick_single: assert property (mc_tick |=> !mc_tick)
    else $error("machine tick lasted more than one clock");
endmodule

`default_nettype wire

// >>> rtl/frt_timer.sv
/*
 * fixed rate interval timer with apb registers and core interrupt
 * handshake. the serial bus interface itself lives elsewhere; only its
 * mode bits, restart pulse and timeout pulse meet this block.
 * assumes apb master per amba apb, core pulses one clock wide.
 */
// How it works
// - count advances once per machine cycle, pclk divided by twelve.
// - counting only while the run bit, config bit 4, is one.
// - writing run to zero stops the timer and zeroes the count.
// - ten bit counter; carry at 1024 sets the timer flag.
// - request needs flag, timer enable bit 4 and global bit 7.
// - taken interrupt branches to fixed vector 1b hex.
// - on acceptance only the program counter is pushed.
// - writing one to config bit 5 clears the timer flag.
// - serial mode bits all zero: serial events never touch timer.
// - hardware reset clears all three serial mode bits.
// - after carry the timer keeps counting; flags 1024 cycles apart.
// - in-progress state released only by a return from interrupt.
// - with serial mode active the timer is the bus timeout.
`default_nettype none

module frt_timer #(
  parameter int DIV = frt_pkg::MACHINE_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sys_rst,
  input wire logic serial_restart,
  input wire logic irq_taken,
  input wire logic ret_exec,
  output logic timer_irq_req,
  output logic [7:0] irq_vector,
  output logic push_pc,
  output logic bus_timeout,
  output logic irq
);
  localparam int W = frt_pkg::CNT_W;

  initial begin
    if (DIV != frt_pkg::MACHINE_DIV) begin
      $error("frt_timer: machine cycle must be twelve clocks");
    end
  end

  // ----------------------------------------------------------------
  // machine cycle tick
  // ----------------------------------------------------------------
  logic mc_tick;

  frt_mc_tick #(.DIV(DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .mc_tick(mc_tick)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic hit_cfg;
  logic hit_ien;
  logic hit_st;
  logic hit_msk;
  logic hit_cnt;
  logic hit_core;
  logic mapped;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign hit_cfg = (paddr == frt_pkg::SERIAL_CONFIG_OFS);
  assign hit_ien = (paddr == frt_pkg::IRQ_ENABLE_OFS);
  assign hit_st = (paddr == frt_pkg::IRQ_STATUS_OFS);
  assign hit_msk = (paddr == frt_pkg::IRQ_MASK_OFS);
  assign hit_cnt = (paddr == frt_pkg::COUNT_OFS);
  assign hit_core = (paddr == frt_pkg::CORE_STATE_OFS);
  assign mapped = hit_cfg || hit_ien || hit_st || hit_msk || hit_cnt ||
                  hit_core;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic run_reg;
  logic run_next;
  logic slave_en_reg;
  logic slave_en_next;
  logic own_req_reg;
  logic own_req_next;
  logic owner_reg;
  logic owner_next;
  logic tmr_en_reg;
  logic tmr_en_next;
  logic glb_en_reg;
  logic glb_en_next;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic busy_reg;
  logic busy_next;
  logic push_reg;
  logic push_next;
  logic tmo_reg;
  logic tmo_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic serial_active;
  logic carry;
  logic clr_flag;
  logic accept;

  assign serial_active = slave_en_reg || own_req_reg || owner_reg;
  assign carry = mc_tick && run_reg && (count_reg == {W{1'b1}});
  assign clr_flag = wr && hit_cfg && pwdata[frt_pkg::TIMER_FLAG_CLEAR_POS];
  assign accept = irq_taken && timer_irq_req;

  always_comb begin
    count_next = count_reg;
    run_next = run_reg;
    slave_en_next = slave_en_reg;
    own_req_next = own_req_reg;
    owner_next = owner_reg;
    tmr_en_next = tmr_en_reg;
    glb_en_next = glb_en_reg;
    status_next = status_reg;
    mask_next = mask_reg;
    busy_next = busy_reg;
    push_next = 1'b0;
    tmo_next = 1'b0;

    if (wr && hit_cfg) begin
      run_next = pwdata[frt_pkg::TIMER_RUN_POS];
      slave_en_next = pwdata[frt_pkg::SLAVE_ENABLE_POS];
      own_req_next = pwdata[frt_pkg::BUS_OWN_REQ_POS];
      owner_next = pwdata[frt_pkg::BUS_OWNER_POS];
    end
    if (wr && hit_ien) begin
      tmr_en_next = pwdata[frt_pkg::TIMER_IRQ_EN_POS];
      glb_en_next = pwdata[frt_pkg::GLOBAL_IRQ_EN_POS];
    end
    if (wr && hit_msk) begin
      mask_next = pwdata[1:0];
    end
    // status bits are write one to clear
    if (wr && hit_st) begin
      status_next = status_reg & ~pwdata[1:0];
    end
    if (clr_flag) begin
      status_next[frt_pkg::ST_TIMER_POS] = 1'b0;
    end

    // run low holds count at zero
    if (!run_reg) begin
      count_next = '0;
    end else if (serial_active && serial_restart) begin
      count_next = '0;
    end else if (mc_tick) begin
      count_next = count_reg + W'(1);
    end

    // set wins over status and flag clear writes in the same cycle; sys_rst below still clears the timer flag
    if (carry) begin
      if (serial_active) begin
        tmo_next = 1'b1;
        status_next[frt_pkg::ST_BUS_TMO_POS] = 1'b1;
      end else begin
        status_next[frt_pkg::ST_TIMER_POS] = 1'b1;
      end
    end

    if (ret_exec) begin
      busy_next = 1'b0;
    end
    if (accept) begin
      busy_next = 1'b1;
      push_next = 1'b1;
    end

    if (sys_rst) begin
      count_next = '0;
      run_next = 1'b0;
      status_next[frt_pkg::ST_TIMER_POS] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data, latched in the setup phase
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = rd_reg;
    if (setup) begin
      rd_next = frt_pkg::REG_RESET;
      if (hit_cfg) begin
        rd_next[frt_pkg::SLAVE_ENABLE_POS] = slave_en_reg;
        rd_next[frt_pkg::BUS_OWN_REQ_POS] = own_req_reg;
        rd_next[frt_pkg::BUS_OWNER_POS] = owner_reg;
        rd_next[frt_pkg::TIMER_RUN_POS] = run_reg;
      end
      if (hit_ien) begin
        rd_next[frt_pkg::TIMER_IRQ_EN_POS] = tmr_en_reg;
        rd_next[frt_pkg::GLOBAL_IRQ_EN_POS] = glb_en_reg;
      end
      if (hit_st) begin
        rd_next[1:0] = status_reg;
      end
      if (hit_msk) begin
        rd_next[1:0] = mask_reg;
      end
      if (hit_cnt) begin
        rd_next[W-1:0] = count_reg;
      end
      if (hit_core) begin
        rd_next[frt_pkg::IN_PROGRESS_POS] = busy_reg;
      end
    end
  end

  // hardware reset clears serial mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      run_reg <= 1'b0;
      slave_en_reg <= 1'b0;
      own_req_reg <= 1'b0;
      owner_reg <= 1'b0;
      tmr_en_reg <= 1'b0;
      glb_en_reg <= 1'b0;
      status_reg <= '0;
      mask_reg <= frt_pkg::MASK_RESET;
      busy_reg <= 1'b0;
      push_reg <= 1'b0;
      tmo_reg <= 1'b0;
      rd_reg <= frt_pkg::REG_RESET;
    end else begin
      count_reg <= count_next;
      run_reg <= run_next;
      slave_en_reg <= slave_en_next;
      own_req_reg <= own_req_next;
      owner_reg <= owner_next;
      tmr_en_reg <= tmr_en_next;
      glb_en_reg <= glb_en_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      busy_reg <= busy_next;
      push_reg <= push_next;
      tmo_reg <= tmo_next;
      rd_reg <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = rd_reg;
  // three-way gate; nesting held off until return
  assign timer_irq_req = status_reg[frt_pkg::ST_TIMER_POS] && tmr_en_reg &&
                         glb_en_reg && !busy_reg;
  assign irq_vector = frt_pkg::TIMER_VECTOR;
  assign push_pc = push_reg;
  assign bus_timeout = tmo_reg;
  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_step: assert property (
    (mc_tick && run_reg && !sys_rst && !(wr && hit_cfg) &&
     !(serial_active && serial_restart))
    |=> count_reg == W'($past(count_reg) + W'(1)))
    else $error("count did not step on machine tick");
  a_count_idle: assert property (
    (!mc_tick && !(serial_active && serial_restart) && !sys_rst)
    |=> count_reg == $past(count_reg) || !$past(run_reg))
    else $error("count moved without a machine tick");
  a_stop_zero: assert property ((!run_reg) |=> count_reg == '0)
    else $error("count not zero while stopped");
  a_carry_flag: assert property (
    (carry && !serial_active && !sys_rst)
    |=> status_reg[frt_pkg::ST_TIMER_POS] && count_reg == '0)
    else $error("carry did not set flag and wrap");
  a_req_gate: assert property (
    timer_irq_req |-> status_reg[frt_pkg::ST_TIMER_POS] && tmr_en_reg &&
                      glb_en_reg)
    else $error("request raised without flag and enables");
  a_vector_fixed: assert property (irq_vector == 8'h1b)
    else $error("interrupt vector is not 1b");
  a_push_once: assert property (
    accept |=> push_pc ##1 !push_pc)
    else $error("push not one clock after acceptance");
  a_flag_clear: assert property (
    (clr_flag && !carry && !sys_rst)
    |=> !status_reg[frt_pkg::ST_TIMER_POS])
    else $error("flag clear write ignored");
  a_serial_iso: assert property (
    (!serial_active && run_reg && serial_restart && !sys_rst)
    |=> count_reg == W'($past(count_reg) + W'($past(mc_tick))) &&
        !bus_timeout)
    else $error("serial activity touched the timer");
  a_return_from_interrupt_release: assert property (
    (busy_reg && !ret_exec && !accept) |=> busy_reg)
    else $error("in-progress dropped without a return");
  a_sys_reset: assert property (
    sys_rst |=> !run_reg && count_reg == '0 &&
                !status_reg[frt_pkg::ST_TIMER_POS])
    else $error("system reset left timer state");
endmodule

`default_nettype wire

// >>> testbench/frt_core_model.sv
/*
 * behavioural model of the processor core and its interrupt system.
 * assumes the timer's request is a level and the core pulses are one
 * pclk wide; the bench opens the return through ret_go.
 */
`default_nettype none

module frt_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic timer_irq_req,
  input wire logic push_pc,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] wait_cyc,
  input wire logic ret_go,
  output logic irq_taken,
  output logic ret_exec,
  output logic [7:0] vec_seen,
  output int push_count
);
  timeunit 1ns;
  timeprecision 100ps;

  logic in_isr;
  logic [3:0] dly;

  // ----------------------------------------------------------------
  // acceptance and return
  // ----------------------------------------------------------------
  // release only by return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_isr <= 1'b0;
      dly <= 4'h0;
      irq_taken <= 1'b0;
      ret_exec <= 1'b0;
      vec_seen <= 8'h00;
      push_count <= 0;
    end else begin
      irq_taken <= 1'b0;
      ret_exec <= 1'b0;
      if (push_pc) begin
        push_count <= push_count + 1;
        vec_seen <= irq_vector;
      end
      // wait_cyc lets a scenario answer slowly instead of at once
      if (!in_isr && timer_irq_req && dly >= wait_cyc) begin
        irq_taken <= 1'b1;
        in_isr <= 1'b1;
        dly <= 4'h0;
      end else if (!in_isr && timer_irq_req) begin
        dly <= dly + 4'h1;
      end else if (in_isr && ret_go && !ret_exec) begin
        ret_exec <= 1'b1;
        in_isr <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// >>> testbench/fixed_rate_interval_timer_test.sv
/*
 * self-checking bench for the fixed rate interval timer over apb.
 * assumes frt_pkg, frt_timer and frt_core_model are compiled first.
 */
`default_nettype none

module fixed_rate_interval_timer_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk, presetn, psel, penable, pwrite, sys_rst, serial_restart;
  logic [7:0] paddr, irq_vector, vec_seen;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, irq_taken, ret_exec, timer_irq_req, push_pc;
  logic bus_timeout, irq, ret_go, er;
  logic [3:0] wait_cyc;
  int push_count, bad_count, num_checks, t0, t1, n;
  int unsigned cyc;

  frt_timer frt_timer_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sys_rst,
    .serial_restart, .irq_taken, .ret_exec, .timer_irq_req, .irq_vector,
    .push_pc, .bus_timeout, .irq);
  frt_core_model frt_core_model_i (.pclk, .presetn, .timer_irq_req,
    .push_pc, .irq_vector, .wait_cyc, .ret_go, .irq_taken, .ret_exec,
    .vec_seen, .push_count);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic ticks(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        bad_count++;
        end_sim();
      end
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    ticks(4);
    presetn <= 1'b1;
  endtask

  task automatic pulse_ret();
    ret_go <= 1'b1;
    ticks(3);
    ret_go <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int e;
    int r;
    presetn = 1'b0;
    {psel, penable, pwrite, sys_rst, serial_restart, ret_go} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    wait_cyc = 4'h0;
    cyc = 0;
    void'($urandom(52));
    do_reset();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rd, (i == 3) ? 32'h3 : 32'h0);
      chk("slverr", er, i == 6);
    end
    $display("test reset done");

    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h10);
    t0 = cyc;
    ticks($urandom_range(500, 50));
    // serial events while all mode bits are clear
    serial_restart <= 1'b1;
    ticks(1);
    serial_restart <= 1'b0;
    apb(1'b0, frt_pkg::COUNT_OFS, 32'h0);
    e = (cyc - t0) / frt_pkg::MACHINE_DIV;
    chk("count rate", rd + 2 >= e && rd <= e + 2, 1'b1);
    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h0);
    apb(1'b0, frt_pkg::COUNT_OFS, 32'h0);
    chk("count stop", rd, 32'h0);
    ticks(100);
    apb(1'b0, frt_pkg::COUNT_OFS, 32'h0);
    chk("count idle", rd, 32'h0);
    $display("test count done");

    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h10);
    t0 = cyc;
    wait_irq(12400);
    t1 = cyc;
    chk("first carry", t1 - t0 >= 12270 && t1 - t0 <= 12300, 1'b1);
    chk("no request", timer_irq_req, 1'b0);
    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h30);
    apb(1'b0, frt_pkg::IRQ_STATUS_OFS, 32'h0);
    chk("flag clear", rd, 32'h0);
    apb(1'b0, frt_pkg::SERIAL_CONFIG_OFS, 32'h0);
    chk("config", rd, 32'h10);
    wait_irq(12400);
    chk("carry period", cyc - t1, 32'd12288);
    $display("test carry done");

    wait_cyc <= 4'hf;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, frt_pkg::IRQ_ENABLE_OFS, {24'h0, i[1], 2'b0, i[0], 4'h0});
      ticks(1);
      chk("request gate", timer_irq_req, i == 3);
    end
    apb(1'b1, frt_pkg::IRQ_MASK_OFS, 32'h0);
    ticks(1);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, frt_pkg::IRQ_MASK_OFS, 32'h3);
    ticks(1);
    chk("irq unmasked", irq, 1'b1);
    n = 0;
    while (push_count < 1 && n < 100) begin
      ticks(1);
      n++;
    end
    chk("push once", push_count, 1);
    chk("vector", vec_seen, frt_pkg::TIMER_VECTOR);
    chk("request held", timer_irq_req, 1'b0);
    apb(1'b0, frt_pkg::CORE_STATE_OFS, 32'h0);
    chk("in progress", rd, 32'h1);
    apb(1'b1, frt_pkg::IRQ_STATUS_OFS, 32'h1);
    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h0);
    pulse_ret();
    apb(1'b0, frt_pkg::CORE_STATE_OFS, 32'h0);
    chk("released", rd, 32'h0);
    ticks(200);
    chk("one shot", irq, 1'b0);
    $display("test interrupt done");

    wait_cyc <= 4'h0;
    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h10);
    for (int i = 0; i < 2; i++) begin
      r = $urandom_range(11500, 6000);
      n = 0;
      repeat (r) begin
        ticks(1);
        if (irq !== 1'b0) n++;
      end
      chk("no bite", n, 0);
      apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h0);
      apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h10);
    end
    wait_irq(12400);
    ticks(4);
    chk("bite taken", push_count, 2);
    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h20);
    pulse_ret();
    $display("test watchdog done");

    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h11);
    ticks(600);
    serial_restart <= 1'b1;
    ticks(1);
    serial_restart <= 1'b0;
    apb(1'b0, frt_pkg::COUNT_OFS, 32'h0);
    chk("serial restart", rd <= 2, 1'b1);
    n = 0;
    while (bus_timeout !== 1'b1 && n < 12400) begin
      ticks(1);
      n++;
    end
    chk("bus timeout", bus_timeout, 1'b1);
    ticks(1);
    chk("timeout pulse", bus_timeout, 1'b0);
    apb(1'b0, frt_pkg::IRQ_STATUS_OFS, 32'h0);
    chk("timeout status", rd, 32'h2);
    sys_rst <= 1'b1;
    ticks(1);
    sys_rst <= 1'b0;
    apb(1'b0, frt_pkg::SERIAL_CONFIG_OFS, 32'h0);
    chk("sys reset run", rd, 32'h1);
    apb(1'b0, frt_pkg::COUNT_OFS, 32'h0);
    chk("sys reset count", rd, 32'h0);
    apb(1'b1, frt_pkg::SERIAL_CONFIG_OFS, 32'h17);
    do_reset();
    apb(1'b0, frt_pkg::SERIAL_CONFIG_OFS, 32'h0);
    chk("mode bits reset", rd, 32'h0);
    $display("test serial done");
    end_sim();
  end
endmodule

`default_nettype wire
